/* File: hw/csfm_clock_switch.sv */
// Clock switch controller and fail-safe monitor with an APB register file
// Assumes oscillator status pins are asynchronous and clock select is
// consumed by a glitch-free mux; configuration bits are static straps
//
// Notes on behaviour
// RQ1: Nine-bit multiplier field, value plus two, default 50
// RQ2: Six-bit signed trim field, default zero
// RQ3: Software may select any source while switching enabled
// RQ4: Primary submode fixed by configuration strap
// RQ5: Switching and monitor enabled only when config bit 0
// RQ6: Disabled: new select ignored, current shows strap
// RQ7: Disabled: switch request held at zero
// RQ8: Software unlocks before each control byte write
// RQ9: Equal codes abort and clear the request
// RQ10: Valid switch clears lock and fail flags
// RQ11: Start target, wait start-up timer and PLL lock
// RQ12: Count ten new-clock cycles before handover
// RQ13: Completion clears request, copies new to current
// RQ14: Stop old source, keep watchdog RC and secondary
// RQ15: Switching never stalls the processor
// RQ16: Software avoids direct PLL to PLL switches
// RQ17: Monitor keeps low-power RC running always
// RQ18: Failure raises trap and falls back to fast RC
// RQ19: PLL in use falls back to fast RC with PLL
// RQ20: Three-bit source codes as enumerated
// RQ21: Failure sets fail flag, software clears it
// RQ22: Lock bit shows PLL locked or timer expired; code uses only pll enable and synced lock, no timer
// RQ23: Unlock gating and glitch-free clock handover
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "csfm_consts.svh"

module csfm_clock_switch
    import csfm_pkg::*;
#(
    parameter int OST_CYCLES = `CSFM_OST_CYCLES,
    parameter int PLL_LOCK_CYCLES = `CSFM_PLL_LOCK_CYCLES,
    parameter int FAIL_TIMEOUT = `CSFM_FAIL_TIMEOUT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration straps
    input wire logic switch_monitor_config_bit,
    input wire logic [2:0] initial_osc_config,
    input wire logic [1:0] primary_osc_submode_config,
    input wire logic watchdog_enable,
    // Oscillator interface
    input wire csfm_osc_stat_s osc_stat,
    output csfm_osc_en_s osc_en,
    output logic [1:0] primary_submode,
    output logic [2:0] sys_clk_select,
    output logic [8:0] pll_feedback_multiplier,
    output logic [5:0] fast_rc_trim,
    // Events
    output logic clock_fail_trap
);

    logic switch_en;
    logic [1:0] cfg_done;
    csfm_src_e current_osc_select;
    csfm_src_e new_osc_select;
    logic osc_switch_request;
    logic clock_fail_flag;
    logic pll_lock;
    logic secondary_osc_enable;
    logic [1:0] unlock_step;
    logic unlock_hi;
    logic unlock_lo;
    csfm_state_e state;
    csfm_src_e target;
    logic [15:0] wait_cnt;
    logic [2:0] pri_sync, sec_sync, lock_sync;
    logic new_tick, new_tick_d;
    logic int_tick;
    logic [1:0] wdt_sync;
    logic [7:0] fail_cnt;
    logic fail_event;
    logic wr, rd_ok;
    logic new_uses_pll, new_uses_xtal, cur_uses_pri, target_ready;

    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign rd_ok = paddr == `CSFM_OSC_CTRL_OFS || paddr == `CSFM_PLL_FBD_OFS ||
        paddr == `CSFM_FRC_TUNE_OFS || paddr == `CSFM_UNLOCK_OFS ||
        paddr == `CSFM_SRC_STAT_OFS;
    assign pslverr = psel & penable & ~rd_ok;
    assign primary_submode = primary_osc_submode_config; // RQ4

    // Switch and initial source straps are latched one clock after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_done <= 2'b00;
            switch_en <= 1'b0;
        end else begin
            cfg_done <= {cfg_done[0], 1'b1};
            if (!cfg_done[0]) begin
                switch_en <= ~switch_monitor_config_bit; // RQ5
            end
        end
    end

    // Synchronisers for asynchronous oscillator status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_sync <= 3'b000;
            sec_sync <= 3'b000;
            lock_sync <= 3'b000;
        end else begin
            pri_sync <= {pri_sync[1:0], osc_stat.pri_tick};
            sec_sync <= {sec_sync[1:0], osc_stat.sec_tick};
            lock_sync <= {lock_sync[1:0], osc_stat.pll_locked};
        end
    end

    // Free-running toggle paces the settle count for internal targets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_tick <= 1'b0;
        end else begin
            int_tick <= ~int_tick; // RQ12
        end
    end

    // Watchdog enable arrives from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_sync <= 2'b00;
        end else begin
            wdt_sync <= {wdt_sync[0], watchdog_enable};
        end
    end

    always_comb begin
        new_uses_pll = new_osc_select == CSFM_SRC_FRC_PLL ||
            new_osc_select == CSFM_SRC_PRI_PLL;
        new_uses_xtal = new_osc_select == CSFM_SRC_PRI_PLL ||
            new_osc_select == CSFM_SRC_PRI || new_osc_select == CSFM_SRC_SEC;
        cur_uses_pri = current_osc_select == CSFM_SRC_PRI ||
            current_osc_select == CSFM_SRC_PRI_PLL;
        case (new_osc_select)
            CSFM_SRC_PRI, CSFM_SRC_PRI_PLL: new_tick = pri_sync[2];
            CSFM_SRC_SEC: new_tick = sec_sync[2];
            default: new_tick = int_tick;
        endcase
        target_ready = ~new_uses_pll | lock_sync[2];
    end

    // Unlock detector: the two key words in order open both control bytes for one write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_step <= 2'b00;
            unlock_hi <= 1'b0;
            unlock_lo <= 1'b0;
        end else if (wr && paddr == `CSFM_UNLOCK_OFS) begin
            if (pwdata == `CSFM_UNLOCK_KEY1) begin
                unlock_step <= 2'b01;
            end else if (pwdata == `CSFM_UNLOCK_KEY2 && unlock_step == 2'b01) begin
                unlock_step <= 2'b00;
                unlock_hi <= 1'b1; // RQ23
                unlock_lo <= 1'b1; // RQ23
            end else begin
                unlock_step <= 2'b00;
            end
        end else if (wr && paddr == `CSFM_OSC_CTRL_OFS) begin
            unlock_step <= 2'b00;
            unlock_hi <= 1'b0;
            unlock_lo <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_feedback_multiplier <= `CSFM_PLL_MULT_RST; // RQ1
            fast_rc_trim <= `CSFM_TRIM_RST; // RQ2
            secondary_osc_enable <= 1'b0;
        end else if (wr) begin
            if (paddr == `CSFM_PLL_FBD_OFS) begin
                pll_feedback_multiplier <= pwdata[8:0]; // RQ1
            end
            if (paddr == `CSFM_FRC_TUNE_OFS) begin
                fast_rc_trim <= pwdata[5:0]; // RQ2
            end
            if (paddr == `CSFM_OSC_CTRL_OFS && unlock_lo) begin
                secondary_osc_enable <= pwdata[`CSFM_SOSCEN_BIT];
            end
        end
    end

    // New source select, writable only after unlock while switching enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_osc_select <= CSFM_SRC_FRC;
        end else if (!cfg_done[0]) begin
            new_osc_select <= csfm_src_e'(initial_osc_config);
        end else if (wr && paddr == `CSFM_OSC_CTRL_OFS && unlock_hi && switch_en &&
                     state == CSFM_ST_IDLE) begin
            new_osc_select <= csfm_src_e'(pwdata[`CSFM_NEW_LSB +: 3]); // RQ3 RQ6
        end
    end

    // Switch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CSFM_ST_IDLE;
            wait_cnt <= 16'h0000;
            current_osc_select <= CSFM_SRC_FRC;
            target <= CSFM_SRC_FRC;
            osc_switch_request <= 1'b0;
            new_tick_d <= 1'b0;
        end else begin
            new_tick_d <= new_tick;
            if (!cfg_done[0]) begin
                current_osc_select <= csfm_src_e'(initial_osc_config); // RQ6
            end else if (fail_event) begin
                // RQ18 RQ19
                current_osc_select <= (current_osc_select == CSFM_SRC_PRI_PLL)
                    ? CSFM_SRC_FRC_PLL : CSFM_SRC_FRC;
                osc_switch_request <= 1'b0;
                state <= CSFM_ST_IDLE;
            end else begin
                case (state)
                    CSFM_ST_IDLE: begin
                        if (!switch_en) begin
                            osc_switch_request <= 1'b0; // RQ7
                        end else if (wr && paddr == `CSFM_OSC_CTRL_OFS && unlock_lo &&
                                     pwdata[`CSFM_REQ_BIT]) begin
                            osc_switch_request <= 1'b1;
                        end else if (osc_switch_request) begin
                            if (new_osc_select == current_osc_select) begin
                                osc_switch_request <= 1'b0; // RQ9
                            end else begin
                                target <= new_osc_select; // RQ3
                                wait_cnt <= new_uses_xtal ? 16'(OST_CYCLES) : 16'h0000;
                                state <= CSFM_ST_START; // RQ11
                            end
                        end
                    end
                    CSFM_ST_START: begin
                        if (wait_cnt == 16'h0000) begin
                            wait_cnt <= new_uses_pll ? 16'(PLL_LOCK_CYCLES) : 16'h0000;
                            state <= CSFM_ST_LOCK; // RQ11
                        end else begin
                            wait_cnt <= wait_cnt - 16'h0001;
                        end
                    end
                    CSFM_ST_LOCK: begin
                        if (wait_cnt != 16'h0000) begin
                            wait_cnt <= wait_cnt - 16'h0001;
                        end else if (target_ready) begin
                            wait_cnt <= 16'(`CSFM_SETTLE_CYCLES);
                            state <= CSFM_ST_SETTLE;
                        end
                    end
                    CSFM_ST_SETTLE: begin
                        if (wait_cnt == 16'h0000) begin
                            state <= CSFM_ST_SWAP;
                        end else if (new_tick != new_tick_d) begin
                            wait_cnt <= wait_cnt - 16'h0001; // RQ12
                        end
                    end
                    CSFM_ST_SWAP: begin
                        current_osc_select <= target; // RQ13 RQ23
                        osc_switch_request <= 1'b0; // RQ13
                        state <= CSFM_ST_IDLE;
                    end
                    default: state <= CSFM_ST_IDLE;
                endcase
            end
        end
    end

    // Fail monitor: primary activity watched against a timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_cnt <= 8'h00;
            fail_event <= 1'b0;
        end else begin
            fail_event <= 1'b0;
            if (!switch_en || !cur_uses_pri || pri_sync[2] != pri_sync[1]) begin
                fail_cnt <= 8'h00;
            end else if (fail_cnt == 8'(FAIL_TIMEOUT - 1)) begin
                fail_cnt <= 8'h00;
                fail_event <= 1'b1; // RQ18
            end else begin
                fail_cnt <= fail_cnt + 8'h01;
            end
        end
    end

    assign clock_fail_trap = fail_event; // RQ18

    // Fail flag: set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_fail_flag <= 1'b0;
        end else if (fail_event) begin
            clock_fail_flag <= 1'b1; // RQ21
        end else if (state == CSFM_ST_IDLE && osc_switch_request &&
                     new_osc_select != current_osc_select && switch_en) begin
            clock_fail_flag <= 1'b0; // RQ10
        end else if (wr && paddr == `CSFM_OSC_CTRL_OFS && unlock_lo &&
                     !pwdata[`CSFM_CF_BIT]) begin
            clock_fail_flag <= 1'b0; // RQ21
        end
    end

    // Lock status, cleared when a valid switch starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_lock <= 1'b0;
        end else if (state == CSFM_ST_IDLE && osc_switch_request &&
                     new_osc_select != current_osc_select && switch_en) begin
            pll_lock <= 1'b0; // RQ10
        end else begin
            pll_lock <= osc_en.pll & lock_sync[2]; // RQ22
        end
    end

    // Oscillator enables; old source drops once current moves away, except low-power RC and enabled secondary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en <= '0;
            sys_clk_select <= 3'h0;
        end else begin
            sys_clk_select <= current_osc_select; // RQ15
            osc_en.fast_rc_osc <= current_osc_select inside {CSFM_SRC_FRC, CSFM_SRC_FRC_PLL,
                CSFM_SRC_FRC_DIV16, CSFM_SRC_FRC_DIVN} || (state != CSFM_ST_IDLE &&
                target inside {CSFM_SRC_FRC, CSFM_SRC_FRC_PLL, CSFM_SRC_FRC_DIV16,
                CSFM_SRC_FRC_DIVN}) || fail_event; // RQ14
            osc_en.pri <= cur_uses_pri || (state != CSFM_ST_IDLE &&
                target inside {CSFM_SRC_PRI, CSFM_SRC_PRI_PLL}); // RQ11 RQ14
            osc_en.sec <= secondary_osc_enable || current_osc_select == CSFM_SRC_SEC ||
                (state != CSFM_ST_IDLE && target == CSFM_SRC_SEC); // RQ14
            osc_en.low_power_rc_osc <= wdt_sync[1] || switch_en ||
                current_osc_select == CSFM_SRC_LOW_POWER_RC_OSC ||
                (state != CSFM_ST_IDLE && target == CSFM_SRC_LOW_POWER_RC_OSC); // RQ14 RQ17
            osc_en.pll <= current_osc_select inside {CSFM_SRC_FRC_PLL, CSFM_SRC_PRI_PLL} ||
                (state != CSFM_ST_IDLE && target inside {CSFM_SRC_FRC_PLL,
                CSFM_SRC_PRI_PLL}); // RQ11
        end
    end

    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `CSFM_OSC_CTRL_OFS: begin
                    prdata[`CSFM_CUR_LSB +: 3] <= current_osc_select; // RQ20
                    prdata[`CSFM_NEW_LSB +: 3] <= new_osc_select;
                    prdata[`CSFM_LOCK_BIT] <= pll_lock;
                    prdata[`CSFM_CF_BIT] <= clock_fail_flag;
                    prdata[`CSFM_SOSCEN_BIT] <= secondary_osc_enable;
                    prdata[`CSFM_REQ_BIT] <= osc_switch_request;
                end
                `CSFM_PLL_FBD_OFS: prdata[8:0] <= pll_feedback_multiplier;
                `CSFM_FRC_TUNE_OFS: prdata[5:0] <= fast_rc_trim;
                `CSFM_UNLOCK_OFS: prdata[1:0] <= {unlock_hi, unlock_lo};
                `CSFM_SRC_STAT_OFS: prdata[4:0] <= state;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: include/csfm_consts.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion from the clock switch module and the testbench
`ifndef CSFM_CONSTS_SVH
`define CSFM_CONSTS_SVH

`define CSFM_OSC_CTRL_OFS 12'h000
`define CSFM_PLL_FBD_OFS 12'h004
`define CSFM_FRC_TUNE_OFS 12'h008
`define CSFM_UNLOCK_OFS 12'h00C
`define CSFM_SRC_STAT_OFS 12'h010

`define CSFM_CUR_LSB 12
`define CSFM_NEW_LSB 8
`define CSFM_LOCK_BIT 5
`define CSFM_CF_BIT 3
`define CSFM_SOSCEN_BIT 1
`define CSFM_REQ_BIT 0

`define CSFM_PLL_MULT_RST 9'h030
`define CSFM_TRIM_RST 6'h00
`define CSFM_UNLOCK_KEY1 32'h0000_0046
`define CSFM_UNLOCK_KEY2 32'h0000_0057

`define CSFM_SETTLE_CYCLES 10
`define CSFM_CLK_HZ 20000000
`define CSFM_OST_NS 1000
`define CSFM_OST_CYCLES ((`CSFM_OST_NS * (`CSFM_CLK_HZ / 1000000) + 999) / 1000)
`define CSFM_PLL_LOCK_NS 2000
`define CSFM_PLL_LOCK_CYCLES ((`CSFM_PLL_LOCK_NS * (`CSFM_CLK_HZ / 1000000) + 999) / 1000)
`define CSFM_FAIL_TIMEOUT 64

`endif

/* File: include/csfm_pkg.sv */
// Types shared by the clock switch and fail monitor
// Assumes csfm_consts.svh sits on the include path
package csfm_pkg;
    typedef enum logic [2:0] {
        CSFM_SRC_FRC = 3'h0,
        CSFM_SRC_FRC_PLL = 3'h1,
        CSFM_SRC_PRI = 3'h2,
        CSFM_SRC_PRI_PLL = 3'h3,
        CSFM_SRC_SEC = 3'h4,
        CSFM_SRC_LOW_POWER_RC_OSC = 3'h5,
        CSFM_SRC_FRC_DIV16 = 3'h6,
        CSFM_SRC_FRC_DIVN = 3'h7
    } csfm_src_e;

    typedef enum logic [4:0] {
        CSFM_ST_IDLE = 5'b00001,
        CSFM_ST_START = 5'b00010,
        CSFM_ST_LOCK = 5'b00100,
        CSFM_ST_SETTLE = 5'b01000,
        CSFM_ST_SWAP = 5'b10000
    } csfm_state_e;

    // Per-oscillator enables driven to the analog side
    typedef struct packed {
        logic fast_rc_osc;
        logic pri;
        logic sec;
        logic low_power_rc_osc;
        logic pll;
    } csfm_osc_en_s;

    // Ready and activity indicators from the oscillators
    typedef struct packed {
        logic pri_tick;
        logic sec_tick;
        logic pll_locked;
    } csfm_osc_stat_s;
endpackage

/* File: verification/csfm_switch_monitor.sv */
// Port-level checker for the clock switch and fail monitor
// Assumes a bind onto csfm_clock_switch with matching port names
`timescale 1ns/1ps
module csfm_switch_monitor
    import csfm_pkg::*;
(
    // Clock and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Straps and oscillators
    input wire logic switch_monitor_config_bit,
    input wire logic [2:0] initial_osc_config,
    input wire csfm_osc_en_s osc_en,
    input wire logic [2:0] sys_clk_select,
    input wire logic [8:0] pll_feedback_multiplier,
    input wire logic [5:0] fast_rc_trim,
    input wire logic clock_fail_trap
);
    logic [2:0] age;
    logic [8:0] wr_mult;
    logic wr_acc;
    logic rd_acc;
    assign wr_mult = pwdata[8:0];
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // Cycles since reset, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence fail_on_pll;
        clock_fail_trap && $past(sys_clk_select) == 3'h3;
    endsequence
    sequence left_pri_pll;
        $past(sys_clk_select) == 3'h3 && sys_clk_select == 3'h0;
    endsequence
    mult_reset_a: assert property (
        $rose(presetn) |-> pll_feedback_multiplier == 9'h030 && fast_rc_trim == 6'h00)
        else $error("multiplier or trim reset wrong");
    mult_write_a: assert property (
        wr_acc && paddr == 12'h004 |=> pll_feedback_multiplier == $past(wr_mult))
        else $error("multiplier write lost");
    mult_read_a: assert property (
        rd_acc && paddr == 12'h004 |-> prdata == {23'h00_0000, pll_feedback_multiplier})
        else $error("multiplier read wrong");
    strap_src_a: assert property (
        switch_monitor_config_bit && age == 3'h7 |-> sys_clk_select == initial_osc_config)
        else $error("disabled switch moved clock");
    req_held_a: assert property (
        rd_acc && paddr == 12'h000 && switch_monitor_config_bit |-> !prdata[0])
        else $error("request bit not held low");
    trap_falls_a: assert property (
        clock_fail_trap |-> !switch_monitor_config_bit ##[0:3] sys_clk_select inside {3'h0, 3'h1})
        else $error("trap without fallback");
    pll_fall_a: assert property (fail_on_pll |-> ##[0:3] sys_clk_select == 3'h1)
        else $error("pll fallback lost");
    low_power_rc_osc_kept_a: assert property (
        !switch_monitor_config_bit && age == 3'h7 |-> osc_en.low_power_rc_osc)
        else $error("low-power rc stopped");
    frc_pll_on_a: assert property (
        sys_clk_select == 3'h1 && $stable(sys_clk_select) && age == 3'h7
        |-> osc_en.fast_rc_osc && osc_en.pll)
        else $error("fast rc pll source off");
    old_off_a: assert property (left_pri_pll |-> ##[0:2] !osc_en.pri && !osc_en.pll)
        else $error("old source left running");
endmodule

/* File: verification/csfm_testbench.sv */
// Self-checking bench for the clock switch and fail monitor
// Assumes design, package and monitor compile first; binds the monitor
`timescale 1ns/1ps
`include "csfm_consts.svh"
module testbench
    import csfm_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pri_alive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic switch_monitor_config_bit, watchdog_enable, clock_fail_trap;
    logic [2:0] initial_osc_config, sys_clk_select;
    logic [1:0] primary_osc_submode_config, primary_submode;
    logic [8:0] pll_feedback_multiplier;
    logic [5:0] fast_rc_trim;
    csfm_osc_stat_s osc_stat;
    csfm_osc_en_s osc_en;
    int err_count, cmp_count, cyc, t;
    logic [2:0] seq [8] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h3};

    csfm_clock_switch #(.OST_CYCLES(2), .PLL_LOCK_CYCLES(2), .FAIL_TIMEOUT(8)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .switch_monitor_config_bit, .initial_osc_config,
        .primary_osc_submode_config, .watchdog_enable, .osc_stat, .osc_en,
        .primary_submode, .sys_clk_select, .pll_feedback_multiplier, .fast_rc_trim,
        .clock_fail_trap);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Oscillator activity; lock follows the pll enable
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        osc_stat.pri_tick <= osc_stat.pri_tick ^ pri_alive;
        osc_stat.sec_tick <= ~osc_stat.sec_tick;
        osc_stat.pll_locked <= osc_en.pll;
    end

    function automatic logic [31:0] fld(input logic [31:0] x, input int w);
        return x & ((32'h0000_0001 << w) - 32'h0000_0001);
    endfunction

    // Control word keeps the fail flag bit high
    function automatic logic [31:0] ctl(input logic [2:0] n, input logic req);
        return {21'h00_0000, n, 4'h0, 1'b1, 2'b00, req};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic unl();
        apb(12'h00C, 1'b1, `CSFM_UNLOCK_KEY1);
        apb(12'h00C, 1'b1, `CSFM_UNLOCK_KEY2);
    endtask

    task automatic sw(input logic [2:0] n, input logic same);
        int t0;
        int dt;
        unl();
        apb(12'h000, 1'b1, ctl(n, 1'b0));
        unl();
        apb(12'h000, 1'b1, ctl(n, 1'b1));
        t0 = cyc;
        do apb(12'h000, 1'b0, 32'h0000_0000); while (rd[0] !== 1'b0 && cyc - t0 < 500);
        dt = cyc - t0;
        chk("done", 32'(rd[0]), 32'h0000_0000);
        // Lock status trails the old pll by a few cycles
        repeat (8) @(posedge pclk);
        apb(12'h000, 1'b0, 32'h0000_0000);
        chk("cur", 32'(rd[14:12]), 32'(n));
        chk("sel", 32'(sys_clk_select), 32'(n));
        chk("lock", 32'(rd[5]), 32'(n == 3'h1 || n == 3'h3));
        chk("cf", 32'(rd[3]), 32'h0000_0000);
        chk("wait", 32'(dt >= 10), 32'(!same));
    endtask

    task automatic rst(input logic off, input logic [2:0] src);
        presetn <= 1'b0;
        switch_monitor_config_bit <= off;
        initial_osc_config <= src;
        primary_osc_submode_config <= 2'($urandom);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, watchdog_enable} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        osc_stat = '0;
        pri_alive = 1'b1;
        cyc = 0;
        err_count = 0;
        cmp_count = 0;
        switch_monitor_config_bit = 1'b1;
        initial_osc_config = 3'h2;
        primary_osc_submode_config = 2'h0;
        void'($urandom(26));
        @(posedge pclk);
        // Switching disabled by strap
        rst(1'b1, 3'h2);
        chk("sub", 32'(primary_submode), 32'(primary_osc_submode_config));
        apb(12'h004, 1'b0, 32'h0000_0000);
        chk("mult rst", rd, 32'h0000_0030);
        apb(12'h008, 1'b0, 32'h0000_0000);
        chk("trim rst", rd, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0020 : $urandom;
            v = (i == 2) ? 32'h0000_001F : v;
            apb(12'h004, 1'b1, v);
            apb(12'h008, 1'b1, v);
            apb(12'h004, 1'b0, 32'h0000_0000);
            chk("mult", rd, fld(v, 9));
            apb(12'h008, 1'b0, 32'h0000_0000);
            chk("trim", rd, fld(v, 6));
        end
        unl();
        apb(12'h000, 1'b1, ctl(3'h0, 1'b1));
        apb(12'h000, 1'b0, 32'h0000_0000);
        chk("off req", 32'(rd[0]), 32'h0000_0000);
        chk("off cur", 32'(rd[14:12]), 32'h0000_0002);
        chk("off sel", 32'(sys_clk_select), 32'h0000_0002);
        apb(12'h020, 1'b0, 32'h0000_0000);
        chk("bad err", 32'(er), 32'h0000_0001);
        chk("bad rd", rd, 32'h0000_0000);
        // Switching enabled, starting on primary with pll
        rst(1'b0, 3'h3);
        apb(12'h000, 1'b1, ctl(3'h5, 1'b1));
        apb(12'h000, 1'b0, 32'h0000_0000);
        chk("no unlock", 32'(rd[10:8]), 32'h0000_0003);
        chk("no req", 32'(rd[0]), 32'h0000_0000);
        sw(3'h3, 1'b1);
        foreach (seq[i]) sw(seq[i], 1'b0);
        pri_alive <= 1'b0;
        t = 0;
        while (clock_fail_trap !== 1'b1 && t < 300) begin
            @(posedge pclk);
            t++;
        end
        chk("trap", 32'(clock_fail_trap), 32'h0000_0001);
        repeat (4) @(posedge pclk);
        chk("fall", 32'(sys_clk_select), 32'h0000_0001);
        apb(12'h000, 1'b0, 32'h0000_0000);
        chk("cf set", 32'(rd[3]), 32'h0000_0001);
        sw(3'h0, 1'b0);
        test_done();
    end
endmodule

bind csfm_clock_switch csfm_switch_monitor u_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .switch_monitor_config_bit, .initial_osc_config, .osc_en, .sys_clk_select,
    .pll_feedback_multiplier, .fast_rc_trim, .clock_fail_trap);
